// File: hw/ppo_top.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - Output data forms four-bit groups that run independently; groups 3 and 2 have pins.
// - Group 3 drives pulse pins 15 to 12 and group 2 drives pins 11 to 8, all outputs only.
// - A sixteen bit timer is the time base; its three events and the software strobe are the output triggers.
// - On a group trigger every bit with its next enable set takes its next value bit.
// - A bit whose next enable is clear keeps its output data when a trigger comes.
// - Software writes to an output data bit whose next enable is set are ignored.
// - After reset all next enable bits and all output data bits read zero.
// - Software picks the trigger source of each group separately.
// - Next value registers hold what the outputs show at the next trigger.
module ppo_top
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:8] pulse_pin
);

   // ************************************************************
   // Declarations.
   // ************************************************************
   ppo_pkg::ppo_regs_s regs;
   ppo_pkg::ppo_regs_s next_regs;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic soft_trig;
   logic next_soft_trig;
   logic [15:0] tmr_count;
   logic [2:0] tmr_evt;
   logic [3:0] trig_src;
   logic [3:0] grp_trig;
   logic [15:0] xfer_mask;
   logic apb_setup;
   logic apb_write;
   logic rd_hit;
   logic [15:0] wr_data;

   // ************************************************************
   // Time base.
   // ************************************************************

   // The timer runs only while software has set its run bit.
   ppo_timebase u_timebase
   (
      .mclk(mclk),
      .reset(reset),
      .run(regs.tmr_run),
      .period(regs.period),
      .cmp_a(regs.cmp_a),
      .cmp_b(regs.cmp_b),
      .count(tmr_count),
      .evt(tmr_evt)
   );

   // Period match, compare A, compare B and the software strobe are the sources.
   assign trig_src = {soft_trig, tmr_evt};

   // ************************************************************
   // Trigger selection and transfer mask.
   // ************************************************************

   // Each group has its own selector, so groups never wait on each other.
   genvar g;
   generate
      for (g = 0; g < ppo_pkg::NUM_GROUPS; g++)
      begin : gen_group
         assign grp_trig[g] =
            trig_src[regs.trig_sel[g*ppo_pkg::SEL_W +: ppo_pkg::SEL_W]];
         assign xfer_mask[g*ppo_pkg::GROUP_W +: ppo_pkg::GROUP_W] =
            {ppo_pkg::GROUP_W{grp_trig[g]}} &
            regs.enable[g*ppo_pkg::GROUP_W +: ppo_pkg::GROUP_W];
      end
   endgenerate

   // ************************************************************
   // APB decode.
   // ************************************************************

   // The slave answers in the first access cycle, so pready is a registered setup flag.
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pready & pwrite;
   assign wr_data = {8'h00, pwdata[7:0]};

   // Read data is captured during setup, so prdata can leave straight from a flop.
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == ppo_pkg::OFS_NEXT_ENABLE_HIGH)
      begin
         next_prdata = {24'h00_0000, regs.enable[15:8]};
      end
      else if (paddr == ppo_pkg::OFS_NEXT_ENABLE_LOW)
      begin
         next_prdata = {24'h00_0000, regs.enable[7:0]};
      end
      else if (paddr == ppo_pkg::OFS_OUTPUT_DATA_HIGH)
      begin
         next_prdata = {24'h00_0000, regs.out_data[15:8]};
      end
      else if (paddr == ppo_pkg::OFS_OUTPUT_DATA_LOW)
      begin
         next_prdata = {24'h00_0000, regs.out_data[7:0]};
      end
      else if (paddr == ppo_pkg::OFS_NEXT_VALUE_HIGH)
      begin
         next_prdata = {24'h00_0000, regs.next_val[15:8]};
      end
      else if (paddr == ppo_pkg::OFS_NEXT_VALUE_LOW)
      begin
         next_prdata = {24'h00_0000, regs.next_val[7:0]};
      end
      else if (paddr == ppo_pkg::OFS_TRIGGER_SELECT)
      begin
         next_prdata = {24'h00_0000, regs.trig_sel};
      end
      else if (paddr == ppo_pkg::OFS_TIMER_CONTROL)
      begin
         next_prdata = {31'h0000_0000, regs.tmr_run};
      end
      else if (paddr == ppo_pkg::OFS_TIMER_PERIOD)
      begin
         next_prdata = {16'h0000, regs.period};
      end
      else if (paddr == ppo_pkg::OFS_TIMER_COMPARE_A)
      begin
         next_prdata = {16'h0000, regs.cmp_a};
      end
      else if (paddr == ppo_pkg::OFS_TIMER_COMPARE_B)
      begin
         next_prdata = {16'h0000, regs.cmp_b};
      end
      else if (paddr == ppo_pkg::OFS_TIMER_COUNT)
      begin
         next_prdata = {16'h0000, tmr_count};
      end
      else if (paddr == ppo_pkg::OFS_SOFT_TRIGGER)
      begin
         next_prdata = 32'h0000_0000;
      end
      else
      begin
         rd_hit = 1'b0;
      end
   end

   // ************************************************************
   // Register next values.
   // ************************************************************

   // Software writes land first, then trigger transfers overwrite enabled bits.
   always_comb
   begin
      next_regs = regs;
      next_soft_trig = 1'b0;
      next_pready = apb_setup;
      next_pslverr = apb_setup & ~rd_hit;
      if (apb_write)
      begin
         if (paddr == ppo_pkg::OFS_NEXT_ENABLE_HIGH)
         begin
            next_regs.enable[15:8] = wr_data[7:0];
         end
         else if (paddr == ppo_pkg::OFS_NEXT_ENABLE_LOW)
         begin
            next_regs.enable[7:0] = wr_data[7:0];
         end
         else if (paddr == ppo_pkg::OFS_OUTPUT_DATA_HIGH)
         begin
            next_regs.out_data[15:8] = (regs.out_data[15:8] & regs.enable[15:8]) |
               (wr_data[7:0] & ~regs.enable[15:8]);
         end
         else if (paddr == ppo_pkg::OFS_OUTPUT_DATA_LOW)
         begin
            next_regs.out_data[7:0] = (regs.out_data[7:0] & regs.enable[7:0]) |
               (wr_data[7:0] & ~regs.enable[7:0]);
         end
         else if (paddr == ppo_pkg::OFS_NEXT_VALUE_HIGH)
         begin
            next_regs.next_val[15:8] = wr_data[7:0];
         end
         else if (paddr == ppo_pkg::OFS_NEXT_VALUE_LOW)
         begin
            next_regs.next_val[7:0] = wr_data[7:0];
         end
         else if (paddr == ppo_pkg::OFS_TRIGGER_SELECT)
         begin
            next_regs.trig_sel = wr_data[7:0];
         end
         else if (paddr == ppo_pkg::OFS_TIMER_CONTROL)
         begin
            next_regs.tmr_run = pwdata[0];
         end
         else if (paddr == ppo_pkg::OFS_TIMER_PERIOD)
         begin
            next_regs.period = pwdata[15:0];
         end
         else if (paddr == ppo_pkg::OFS_TIMER_COMPARE_A)
         begin
            next_regs.cmp_a = pwdata[15:0];
         end
         else if (paddr == ppo_pkg::OFS_TIMER_COMPARE_B)
         begin
            next_regs.cmp_b = pwdata[15:0];
         end
         else if (paddr == ppo_pkg::OFS_SOFT_TRIGGER)
         begin
            next_soft_trig = pwdata[0];
         end
      end
      // Enabled and writable bits are disjoint, so the transfer never fights a write.
      next_regs.out_data = (next_regs.out_data & ~xfer_mask) |
         (regs.next_val & xfer_mask);
   end

   // ************************************************************
   // State registers.
   // ************************************************************

   // The pins have their own flops, loaded with the same next output data byte, so no glitch reaches a load.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         regs.enable <= ppo_pkg::RST_ENABLE;
         regs.out_data <= ppo_pkg::RST_OUT_DATA;
         regs.next_val <= ppo_pkg::RST_NEXT_VAL;
         regs.trig_sel <= ppo_pkg::RST_TRIG_SEL;
         regs.tmr_run <= 1'b0;
         regs.period <= ppo_pkg::RST_PERIOD;
         regs.cmp_a <= ppo_pkg::RST_COMPARE;
         regs.cmp_b <= ppo_pkg::RST_COMPARE;
         soft_trig <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         pulse_pin <= 8'h00;
      end
      else
      begin
         regs <= next_regs;
         soft_trig <= next_soft_trig;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         pulse_pin <= next_regs.out_data[15:8];
      end
   end

   // ************************************************************
   // Assertions.
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   // A write to the high output data byte in its access phase.
   sequence s_od_high_write;
      psel && penable && pready && pwrite && (paddr == ppo_pkg::OFS_OUTPUT_DATA_HIGH);
   endsequence

   // The high byte is fully enabled and no trigger is pending.
   sequence s_locked_idle;
      (regs.enable[15:8] == 8'hFF) && (xfer_mask[15:8] == 8'h00);
   endsequence

   AST_TRANSFER: assert property (
      (xfer_mask != 16'h0000) |=>
         ((regs.out_data & $past(xfer_mask)) == ($past(regs.next_val) & $past(xfer_mask))))
      else $error("Enabled bit did not take its next value on a trigger.");

   AST_HOLD: assert property (
      !apb_write |=>
         ((regs.out_data & ~$past(xfer_mask)) == ($past(regs.out_data) & ~$past(xfer_mask))))
      else $error("Output data changed on a bit without a transfer.");

   AST_LOCKED: assert property (
      (s_od_high_write ##0 s_locked_idle) |=> $stable(regs.out_data[15:8]))
      else $error("Software write changed an enabled output data bit.");

   AST_RESET: assert property (
      disable iff (1'b0) reset |=> (regs.enable == 16'h0000) && (regs.out_data == 16'h0000))
      else $error("Enable or output data not clear after reset.");

   AST_PINS: assert property (
      (xfer_mask[15:8] != 8'h00) |=>
         ((pulse_pin & $past(xfer_mask[15:8])) ==
            ($past(regs.next_val[15:8]) & $past(xfer_mask[15:8]))))
      else $error("Pulse pins do not follow output data after a trigger.");

   AST_GROUP_SEL: assert property (
      grp_trig[3] == (((regs.trig_sel[7:6] == 2'h0) && tmr_evt[0]) ||
         ((regs.trig_sel[7:6] == 2'h1) && tmr_evt[1]) ||
         ((regs.trig_sel[7:6] == 2'h2) && tmr_evt[2]) ||
         ((regs.trig_sel[7:6] == 2'h3) && soft_trig)))
      else $error("Group 3 trigger does not follow its selected source.");

   AST_NEXT_VALUE: assert property (
      (apb_write && (paddr == ppo_pkg::OFS_NEXT_VALUE_HIGH)) |=>
         (regs.next_val[15:8] == $past(pwdata[7:0])))
      else $error("Next value high byte not stored on write.");

   AST_PERIOD_EVT: assert property (
      tmr_evt[0] |-> (tmr_count == 16'h0000))
      else $error("Period event without the counter clearing.");

   AST_GROUP_INDEP: assert property (
      (grp_trig[2] && !grp_trig[3] && !apb_write) |=> $stable(regs.out_data[15:12]))
      else $error("Group 2 trigger disturbed group 3 outputs.");

   AST_APB_READY: assert property (
      apb_setup |=> pready ##1 !pready || apb_setup)
      else $error("APB answer not given in the first access cycle.");

endmodule : ppo_top

// File: pkg/ppo_pkg.sv
// ************************************************************
// Shared constants and types of the pulse pattern output stage.
// ************************************************************
package ppo_pkg;

   // ************************************************************
   // Register byte addresses on the APB side.
   // ************************************************************
   localparam logic [7:0] OFS_NEXT_ENABLE_HIGH = 8'h00;
   localparam logic [7:0] OFS_NEXT_ENABLE_LOW = 8'h04;
   localparam logic [7:0] OFS_OUTPUT_DATA_HIGH = 8'h08;
   localparam logic [7:0] OFS_OUTPUT_DATA_LOW = 8'h0C;
   localparam logic [7:0] OFS_NEXT_VALUE_HIGH = 8'h10;
   localparam logic [7:0] OFS_NEXT_VALUE_LOW = 8'h14;
   localparam logic [7:0] OFS_TRIGGER_SELECT = 8'h18;
   localparam logic [7:0] OFS_TIMER_CONTROL = 8'h1C;
   localparam logic [7:0] OFS_TIMER_PERIOD = 8'h20;
   localparam logic [7:0] OFS_TIMER_COMPARE_A = 8'h24;
   localparam logic [7:0] OFS_TIMER_COMPARE_B = 8'h28;
   localparam logic [7:0] OFS_TIMER_COUNT = 8'h2C;
   localparam logic [7:0] OFS_SOFT_TRIGGER = 8'h30;

   // ************************************************************
   // Geometry of the data path.
   // ************************************************************
   localparam int NUM_GROUPS = 4;
   localparam int GROUP_W = 4;
   localparam int DATA_W = 16;
   localparam int PIN_LSB = 8;
   localparam int SEL_W = 2;
   localparam int TRG_SOFT = 3;

   // ************************************************************
   // Values after reset.
   // ************************************************************
   localparam logic [15:0] RST_ENABLE = 16'h0000;
   localparam logic [15:0] RST_OUT_DATA = 16'h0000;
   localparam logic [15:0] RST_NEXT_VAL = 16'h0000;
   localparam logic [7:0] RST_TRIG_SEL = 8'h00;
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;
   localparam logic [15:0] RST_COMPARE = 16'h0000;
   localparam logic [15:0] RST_COUNT = 16'h0000;

   // Software visible state of the output stage, kept together.
   typedef struct packed {
      logic [15:0] enable;
      logic [15:0] out_data;
      logic [15:0] next_val;
      logic [7:0] trig_sel;
      logic tmr_run;
      logic [15:0] period;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
   } ppo_regs_s;

endpackage : ppo_pkg

// File: hw/ppo_timebase.sv
`timescale 1ns/1ps
// ************************************************************
// Sixteen bit time base that supplies the output triggers.
// ************************************************************
module ppo_timebase
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic run,
   input wire logic [15:0] period,
   input wire logic [15:0] cmp_a,
   input wire logic [15:0] cmp_b,
   output logic [15:0] count,
   output logic [2:0] evt
);

   logic [15:0] next_count;
   logic [2:0] next_evt;

   // The counter clears on a period match, so the cycle is period plus one clocks.
   always_comb
   begin
      next_count = count;
      next_evt = 3'h0;
      if (run)
      begin
         next_evt[1] = (count == cmp_a);
         next_evt[2] = (count == cmp_b);
         if (count == period)
         begin
            next_count = ppo_pkg::RST_COUNT;
            next_evt[0] = 1'b1;
         end
         else
         begin
            next_count = count + 16'h0001;
         end
      end
   end

   // Events are registered so every trigger is a clean one-cycle pulse.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         count <= ppo_pkg::RST_COUNT;
         evt <= 3'h0;
      end
      else
      begin
         count <= next_count;
         evt <= next_evt;
      end
   end

endmodule : ppo_timebase

// File: tb/ppo_load_model.sv
`timescale 1ns/1ps
// ************************************************************
// Load seen by the eight pulse pins.
// ************************************************************
module ppo_load_model
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [15:8] pulse_pin,
   output logic [7:0] last_level,
   output int edge_cnt
);
   // The load only listens, so the pins stay pure outputs of the block.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         last_level <= 8'h00;
         edge_cnt <= 0;
      end
      else
      begin
         last_level <= pulse_pin; // Latched level lags the pins by one cycle.
         edge_cnt <= edge_cnt + ((last_level != pulse_pin) ? 1 : 0);
      end
   end
endmodule : ppo_load_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench of the pulse pattern output stage.
// ************************************************************
module tb_top;
   typedef struct packed {logic rd; logic err; logic [31:0] data;} ppo_note_s;
   logic mclk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, last_level;
   logic [31:0] pwdata, prdata;
   logic [15:8] pulse_pin;
   int edge_cnt, error_cnt, cmp_count;
   ppo_note_s note_q[$];
   ppo_note_s cur;

   ppo_top u_ppo_top (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pulse_pin(pulse_pin));
   ppo_load_model u_ppo_load_model (.mclk(mclk), .reset(reset), .pulse_pin(pulse_pin),
      .last_level(last_level), .edge_cnt(edge_cnt));

   // Free running clock, 50 ns period.
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task report_and_stop;
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task automatic fail(input string msg);
      $display("unexpected at %0t: %s", $time, msg);
      error_cnt++;
   endtask : fail

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
         fail("read data mismatch");
   endtask : cmp_word

   task automatic cmp_flag(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
         fail("error response mismatch");
   endtask : cmp_flag

   // The load's latched copy must agree too, so pins are checked once settled.
   task check_pins(input logic [7:0] exp);
      cmp_count++;
      if (pulse_pin !== exp || last_level !== exp)
         fail("pin level mismatch");
   endtask : check_pins

   // One APB transfer; the note is queued before the request goes out.
   task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
            input logic [31:0] exp);
      int n;
      note_q.push_back('{rd: !wr, err: (addr > ppo_pkg::OFS_SOFT_TRIGGER), data: exp});
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         fail("no ready");
         report_and_stop();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data, 32'h0000_0000);
   endtask : wr

   task rd(input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000, exp);
   endtask : rd

   // Each completed transfer retires the oldest note.
   always @(posedge mclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      begin
         if (note_q.size() == 0)
            fail("response without request");
         else
         begin
            cur = note_q.pop_front();
            cmp_flag(pslverr, cur.err);
            if (cur.rd)
               cmp_word(prdata, cur.data);
         end
      end
   end

   // Watchdog so that a hung design still reaches the verdict.
   initial
   begin
      repeat (20000) @(posedge mclk);
      fail("watchdog expired");
      report_and_stop();
   end

   // Main sequence; od_h and en_h model the high output byte.
   initial
   begin
      logic [7:0] od_h, en_h, nv_h, wv, mask;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      error_cnt = 0;
      cmp_count = 0;
      void'($urandom(38092));
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      // Everything reads zero after reset except the timer period.
      for (int a = 0; a <= 8'h30; a += 4)
         rd(a[7:0], (a == 8'h20) ? 32'h0000_FFFF : 32'h0000_0000);
      check_pins(8'h00);
      // Unmapped places answer with an error and read zero.
      wr(8'h34, 32'hFFFF_FFFF);
      rd(8'h34, 32'h0000_0000);
      rd(8'hFC, 32'h0000_0000);
      // Start level loaded while disabled, then enabled bits resist writes.
      for (int b = 0; b < 2; b++)
      begin
         wv = $urandom;
         mask = $urandom;
         wr(ppo_pkg::OFS_OUTPUT_DATA_HIGH + 8'(4 * b), {24'h0, wv});
         rd(ppo_pkg::OFS_OUTPUT_DATA_HIGH + 8'(4 * b), {24'h0, wv});
         wr(ppo_pkg::OFS_NEXT_ENABLE_HIGH + 8'(4 * b), {24'h0, mask});
         rd(ppo_pkg::OFS_NEXT_ENABLE_HIGH + 8'(4 * b), {24'h0, mask});
         wr(ppo_pkg::OFS_OUTPUT_DATA_HIGH + 8'(4 * b), {24'h0, ~wv});
         rd(ppo_pkg::OFS_OUTPUT_DATA_HIGH + 8'(4 * b),
            {24'h0, (wv & mask) | (~wv & ~mask)});
         if (b == 0)
         begin
            en_h = mask;
            od_h = (wv & mask) | (~wv & ~mask);
         end
      end
      repeat (2) @(posedge mclk);
      check_pins(od_h);
      // Software trigger on every group with random next values.
      wr(ppo_pkg::OFS_TRIGGER_SELECT, 32'h0000_00FF);
      repeat (4)
      begin
         nv_h = $urandom;
         wr(ppo_pkg::OFS_NEXT_VALUE_HIGH, {24'h0, nv_h});
         rd(ppo_pkg::OFS_NEXT_VALUE_HIGH, {24'h0, nv_h});
         check_pins(od_h);
         wr(ppo_pkg::OFS_SOFT_TRIGGER, 32'h0000_000F);
         repeat (3) @(posedge mclk);
         od_h = (od_h & ~en_h) | (nv_h & en_h);
         check_pins(od_h);
         rd(ppo_pkg::OFS_OUTPUT_DATA_HIGH, {24'h0, od_h});
      end
      // Group 3 on the soft trigger, group 2 on the period match.
      wr(ppo_pkg::OFS_NEXT_ENABLE_HIGH, 32'h0000_00FF);
      en_h = 8'hFF;
      wr(ppo_pkg::OFS_TRIGGER_SELECT, 32'h0000_00C0);
      nv_h = ~od_h;
      wr(ppo_pkg::OFS_NEXT_VALUE_HIGH, {24'h0, nv_h});
      wr(ppo_pkg::OFS_SOFT_TRIGGER, 32'h0000_000F);
      repeat (3) @(posedge mclk);
      od_h = {nv_h[7:4], od_h[3:0]};
      check_pins(od_h);
      // Every high bit is enabled now, so a software write must leave them all alone.
      wr(ppo_pkg::OFS_OUTPUT_DATA_HIGH, {24'h0, ~od_h});
      rd(ppo_pkg::OFS_OUTPUT_DATA_HIGH, {24'h0, od_h});
      // The timer period match now moves groups 2, 1 and 0, but not group 3.
      wr(ppo_pkg::OFS_TIMER_PERIOD, 32'h0000_0007);
      wr(ppo_pkg::OFS_TIMER_CONTROL, 32'h0000_0001);
      repeat (30) @(posedge mclk);
      wr(ppo_pkg::OFS_TIMER_CONTROL, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      od_h = {od_h[7:4], nv_h[3:0]};
      check_pins(od_h);
      // Both group tests moved the pins, so the load must have seen at least two changes.
      cmp_flag(edge_cnt >= 2, 1'b1);
      // A second reset in mid-run clears the enables and the pins.
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rd(ppo_pkg::OFS_NEXT_ENABLE_HIGH, 32'h0000_0000);
      rd(ppo_pkg::OFS_OUTPUT_DATA_HIGH, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      check_pins(8'h00);
      repeat (2) @(posedge mclk);
      report_and_stop();
   end
endmodule : tb_top
